// File: logic/weh_map.svh
`ifndef WEH_MAP_SVH
`define WEH_MAP_SVH
// clock tail after oscillator disable
`define WEH_CLK_TAIL_PULSES 8'h80
// host clock divider, half period minus one in core clocks, default
`define WEH_CLKDIV_RESET 4'h1
// wake-up timer unit: 1 ms at 200 MHz
`define WEH_WUT_UNIT_NS 1000000
`define WEH_CLK_PERIOD_NS 5
`define WEH_WUT_UNIT_CYC (`WEH_WUT_UNIT_NS / `WEH_CLK_PERIOD_NS)
// brief oscillator hold for calibration, in core clocks
`define WEH_CAL_CYC 16'h0400
// low battery hysteresis: 50 mV in 10 mV units
`define WEH_LB_HYST 9'h005
// status cause bit positions
`define WEH_ST_WUT 0
`define WEH_ST_LB 1
`define WEH_ST_FFULL 2
`define WEH_ST_SER 3
`define WEH_FIFO_DEPTH 16
`endif

// File: logic/weh_pkg.sv
package weh_pkg;
  typedef enum logic [1:0] {
    WEH_IDLE = 2'b00,
    WEH_CAL = 2'b01,
    WEH_RUN = 2'b10
  } weh_wut_state_t;
  typedef logic [3:0] weh_cause_t;
endpackage

// File: logic/weh_link_if.sv
interface weh_link_if;
  logic [3:0] cause;
  logic clear;
  logic [15:0] statusWord;
  logic readActive;
  logic readBit;
  logic [7:0] cmdByte;
  logic cmdValid;
  modport ctrl (input statusWord, output readActive, output readBit, output cmdByte,
    output cmdValid, output clear);
  modport evt (output cause, input clear);
endinterface

// File: logic/weh_serial_port.sv
`include "weh_map.svh"
// three-wire slave: 8-bit command in; command 8'hFF starts a status read
module weh_serial_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pins
  input wire logic serialClk,
  input wire logic serial_select_n,
  input wire logic serial_write_in,
  // to controller
  weh_link_if.ctrl link
);
  logic sckDly;
  logic [7:0] shiftIn;
  logic [3:0] bitCnt;
  logic [15:0] shiftOut;
  logic reading;
  wire rise = serialClk & ~sckDly;
  wire fall = ~serialClk & sckDly;
  wire byteDone = rise & (bitCnt == 4'h7) & ~reading;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sckDly <= 1'b0;
    else
      sckDly <= serialClk;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shiftIn <= 8'h00;
      bitCnt <= 4'h0;
      shiftOut <= 16'h0000;
      reading <= 1'b0;
    end
    else if (serial_select_n)
    begin
      // deselected: ignore the link entirely
      bitCnt <= 4'h0;
      reading <= 1'b0;
    end
    else if (byteDone)
    begin
      shiftIn <= {shiftIn[6:0], serial_write_in};
      bitCnt <= 4'h0;
      reading <= ({shiftIn[6:0], serial_write_in} == 8'hFF);
      shiftOut <= link.statusWord;
    end
    else if (rise)
    begin
      shiftIn <= {shiftIn[6:0], serial_write_in};
      bitCnt <= bitCnt + 4'h1;
    end
    else if (fall && reading)
      shiftOut <= {shiftOut[14:0], 1'b0};
  end
  assign link.cmdByte = {shiftIn[6:0], serial_write_in};
  assign link.cmdValid = byteDone & ~serial_select_n;
  assign link.readActive = reading & ~serial_select_n;
  assign link.readBit = shiftOut[15];
  assign link.clear = link.cmdValid & (link.cmdByte == 8'hFF);
endmodule

// File: logic/weh_event_latch.sv
`include "weh_map.svh"
// sticky wake-up causes; a new event beats the read-clear
module weh_event_latch (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // event pulses
  input wire logic [3:0] evtPulse,
  // to controller
  weh_link_if.evt link
);
  weh_pkg::weh_cause_t cause;
  wire [3:0] next_cause = evtPulse | (cause & {4{~link.clear}});
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cause <= 4'h0;
    else
      cause <= next_cause;
  end
  assign link.cause = cause;
endmodule

// File: logic/weh_control.sv
// Operation
// - after oscillator disable, give exactly 128 more host clock pulses
// - low battery event below threshold, recover only 50 mV above
// - wake-up timer period programmable from 1 ms, accuracy within 10 percent
// - calibrate wake-up timer against crystal at every startup
// - if oscillator off, enable it briefly for calibration then release
// - wake on timer, low supply, FIFO full or serial request
// - every wake-up event asserts the host interrupt request
// - interrupt request output low while an interrupt is pending
// - status read shifts out cause bits on the serial output
// - parameters default at power-on and are kept in sleep
// - clock divider, wake-up timer and low supply detector each disableable
// - 16-bit receive FIFO holds received bits for host readout
// - FIFO buffering only when the FIFO enable bit is one
// - sample shared pin at power-on: rail means standalone, else host clock
// - device ignores the serial link while chip select is high
// - serial output tristated and held by keeper while deselected
// - shared pin carries low FIFO flag, or read data during status read
// - FIFO interrupt active high; level one means not-empty (the shared pin drives it active low; only fifo_threshold_flag is active high)
// - without FIFO, output received data and, with digital filter, its clock
// - drive active-low reset output to the host
// - standalone: read channel and band pins, respond if addressed, drive outputs
`include "weh_map.svh"
module weh_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial link
  input wire logic serialClk,
  input wire logic serial_select_n,
  input wire logic serial_write_in,
  output logic fifo_irq_or_serial_out,
  output logic serialOutEn,
  output logic event_request_n,
  // configuration bits
  input wire logic oscEnable,
  input wire logic [3:0] clkDivHalf,
  input wire logic clkDivEnable,
  input wire logic wutEnable,
  input wire logic [15:0] wutPeriodMs,
  input wire logic lowBattEnable,
  input wire logic [8:0] lowBattThreshold,
  input wire logic [8:0] supplyLevel,
  input wire logic fifo_enable_bit,
  input wire logic [3:0] fifoFillLevel,
  input wire logic digitalFilter,
  input wire logic sleepMode,
  // receive data
  input wire logic rxBit,
  input wire logic rxBitStrobe,
  input wire logic fifo_access_select_n,
  output logic rxDataOut,
  output logic rxClkOut,
  output logic fifo_threshold_flag,
  // shared clock pin and mode
  input wire logic dutySelectIn,
  input wire logic dutySelectDriven,
  output logic hostClockOut,
  output logic hostClockEn,
  output logic standalone,
  output logic dutyCycled,
  output logic oscRun,
  output logic host_reset_n,
  // standalone pins
  input wire logic [3:0] channelSelect,
  input wire logic [1:0] bandSelect,
  input wire logic [7:0] ownAddress,
  output logic [3:0] controlOutputs
);
  // ----------------------------------------
  // serial link and wake-up cause
  // ----------------------------------------
  weh_link_if link ();
  logic [3:0] evtPulse;
  weh_serial_port port (
    .core_clk(core_clk),
    .rstn(rstn),
    .serialClk(serialClk),
    .serial_select_n(serial_select_n),
    .serial_write_in(serial_write_in),
    .link(link.ctrl)
  );
  weh_event_latch latch (
    .core_clk(core_clk),
    .rstn(rstn),
    .evtPulse(evtPulse),
    .link(link.evt)
  );
  // ----------------------------------------
  // power-on mode strap
  // ----------------------------------------
  logic strapDone;
  wire strapHit = ~strapDone;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strapDone <= 1'b0;
      standalone <= 1'b0;
    end
    else if (strapHit)
    begin
      strapDone <= 1'b1;
      standalone <= dutySelectDriven;
    end
  end
  // ----------------------------------------
  // host clock with tail
  // ----------------------------------------
  logic oscPrev;
  logic [7:0] tailCnt;
  logic [3:0] divCnt;
  logic calHold;
  wire tailStart = oscPrev & ~oscEnable;
  wire clkActive = oscEnable | (tailCnt != 8'h00);
  wire divWrap = (divCnt >= clkDivHalf);
  wire risingOut = divWrap & ~hostClockOut;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      oscPrev <= 1'b1;
    else
      oscPrev <= oscEnable;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      tailCnt <= 8'h00;
    else if (tailStart)
      tailCnt <= `WEH_CLK_TAIL_PULSES;
    else if (oscEnable)
      tailCnt <= 8'h00;
    else if (risingOut && tailCnt != 8'h00)
      tailCnt <= tailCnt - 8'h01;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      divCnt <= 4'h0;
      hostClockOut <= 1'b0;
    end
    else if (!clkActive || !clkDivEnable || standalone || !strapDone)
    begin
      divCnt <= 4'h0;
      hostClockOut <= 1'b0;
    end
    else if (divWrap)
    begin
      divCnt <= 4'h0;
      hostClockOut <= ~hostClockOut;
    end
    else
      divCnt <= divCnt + 4'h1;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hostClockEn <= 1'b0;
      oscRun <= 1'b1;
    end
    else
    begin
      hostClockEn <= strapDone & ~standalone;
      oscRun <= clkActive | calHold;
    end
  end
  // ----------------------------------------
  // wake-up timer with calibration
  // ----------------------------------------
  weh_pkg::weh_wut_state_t wutState;
  logic [15:0] calCnt;
  logic [17:0] unitCnt;
  logic [15:0] msCnt;
  logic [15:0] calTrim;
  logic wutPrev;
  localparam logic [17:0] UNIT_CYC = 18'(`WEH_WUT_UNIT_CYC);
  wire wutStart = wutEnable & ~wutPrev;
  wire unitDone = (unitCnt >= UNIT_CYC - 18'h1);
  wire wutTimeout = (wutState == weh_pkg::WEH_RUN) & unitDone & (msCnt >= wutPeriodMs - 16'h1);
  assign calHold = (wutState == weh_pkg::WEH_CAL);
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      wutPrev <= 1'b0;
    else
      wutPrev <= wutEnable;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wutState <= weh_pkg::WEH_IDLE;
      calCnt <= 16'h0000;
      unitCnt <= 18'h00000;
      msCnt <= 16'h0000;
      calTrim <= 16'h0000;
    end
    else
    begin
      case (wutState)
        weh_pkg::WEH_IDLE:
        begin
          if (wutStart)
          begin
            wutState <= weh_pkg::WEH_CAL;
            calCnt <= 16'h0000;
          end
        end
        weh_pkg::WEH_CAL:
        begin
          calCnt <= calCnt + 16'h0001;
          if (calCnt == `WEH_CAL_CYC)
          begin
            calTrim <= calCnt;
            wutState <= weh_pkg::WEH_RUN;
            unitCnt <= 18'h00000;
            msCnt <= 16'h0000;
          end
        end
        weh_pkg::WEH_RUN:
        begin
          if (!wutEnable)
            wutState <= weh_pkg::WEH_IDLE;
          else if (wutTimeout)
          begin
            unitCnt <= 18'h00000;
            msCnt <= 16'h0000;
          end
          else if (unitDone)
          begin
            unitCnt <= 18'h00000;
            msCnt <= msCnt + 16'h0001;
          end
          else
            unitCnt <= unitCnt + 18'h00001;
        end
        default:
          wutState <= weh_pkg::WEH_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // low battery with hysteresis
  // ----------------------------------------
  logic lowBatt;
  wire belowThr = supplyLevel < lowBattThreshold;
  // one bit wider so a threshold near the top cannot wrap the recovery level
  wire [9:0] recoverLevel = {1'b0, lowBattThreshold} + {1'b0, `WEH_LB_HYST};
  wire aboveHyst = {1'b0, supplyLevel} >= recoverLevel;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      lowBatt <= 1'b0;
    else if (!lowBattEnable)
      lowBatt <= 1'b0;
    else if (belowThr)
      lowBatt <= 1'b1;
    else if (aboveHyst)
      lowBatt <= 1'b0;
  end
  // ----------------------------------------
  // receive FIFO
  // ----------------------------------------
  logic [`WEH_FIFO_DEPTH-1:0] fifoMem;
  logic [4:0] fifoCount;
  logic ffsPrev;
  wire fifoFull = (fifoCount == 5'(`WEH_FIFO_DEPTH));
  wire fifoPush = fifo_enable_bit & rxBitStrobe & ~fifoFull;
  wire fifoPop = fifo_enable_bit & ~fifo_access_select_n & ffsPrev & (fifoCount != 5'h00);
  wire fifoFullEvt = fifo_enable_bit & rxBitStrobe & (fifoCount == 5'(`WEH_FIFO_DEPTH - 1));
  // oldest bit sits at the top of the filled part of the shift chain
  wire [3:0] headIdx = fifoCount[3:0] - 4'h1;
  wire fifoHead = fifoMem[headIdx];
  wire next_rxData = fifo_enable_bit ? (fifoPop ? fifoHead : rxDataOut) : rxBit;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ffsPrev <= 1'b1;
    else
      ffsPrev <= fifo_access_select_n;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fifoMem <= 16'h0000;
      fifoCount <= 5'h00;
    end
    else if (!fifo_enable_bit)
      fifoCount <= 5'h00;
    else
    begin
      if (fifoPush)
        fifoMem <= {fifoMem[14:0], rxBit};
      fifoCount <= fifoCount + {4'h0, fifoPush} - {4'h0, fifoPop};
    end
  end
  wire fifoAtLevel = (fifoCount >= {1'b0, fifoFillLevel}) & (fifoCount != 5'h00);
  // ----------------------------------------
  // events, interrupt and pin outputs
  // ----------------------------------------
  logic lowBattPrev;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      lowBattPrev <= 1'b0;
    else
      lowBattPrev <= lowBatt;
  end
  assign evtPulse[`WEH_ST_WUT] = wutTimeout;
  assign evtPulse[`WEH_ST_LB] = lowBatt & ~lowBattPrev;
  assign evtPulse[`WEH_ST_FFULL] = fifoFullEvt;
  assign evtPulse[`WEH_ST_SER] = link.cmdValid & (link.cmdByte != 8'hFF);
  assign link.statusWord = {link.cause, fifoCount, lowBatt, standalone, 5'h00};
  wire addressed = link.cmdValid & (link.cmdByte[7:4] == ownAddress[7:4]);
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      event_request_n <= 1'b1;
      fifo_irq_or_serial_out <= 1'b1;
      serialOutEn <= 1'b0;
      fifo_threshold_flag <= 1'b0;
      rxDataOut <= 1'b0;
      rxClkOut <= 1'b0;
      host_reset_n <= 1'b0;
      dutyCycled <= 1'b0;
      controlOutputs <= 4'h0;
    end
    else
    begin
      // pending cause, or a new event this cycle, pulls the request low
      event_request_n <= ~((|link.cause) | (|evtPulse));
      serialOutEn <= ~serial_select_n;
      // keeper: while deselected the last level is held
      if (!serial_select_n)
        fifo_irq_or_serial_out <= link.readActive ? link.readBit : ~fifoAtLevel;
      fifo_threshold_flag <= fifoAtLevel;
      rxDataOut <= next_rxData;
      rxClkOut <= ~fifo_enable_bit & digitalFilter & rxBitStrobe;
      host_reset_n <= strapDone;
      dutyCycled <= standalone & dutySelectIn & ~sleepMode;
      if (standalone && addressed)
        controlOutputs <= link.cmdByte[3:0] ^ {channelSelect[1:0], bandSelect};
    end
  end
endmodule

// File: verif/weh_control_assertions.sv
module weh_control_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial link
  input wire logic serial_select_n,
  input wire logic fifo_irq_or_serial_out,
  input wire logic serialOutEn,
  input wire logic event_request_n,
  // configuration
  input wire logic oscEnable,
  input wire logic wutEnable,
  input wire logic lowBattEnable,
  input wire logic [8:0] lowBattThreshold,
  input wire logic [8:0] supplyLevel,
  // clock pin and mode
  input wire logic hostClockOut,
  input wire logic hostClockEn,
  input wire logic standalone,
  input wire logic oscRun
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // ----
  // helpers
  // ----
  logic [8:0] tailCnt;
  logic lbLow;
  assign lbLow = lowBattEnable && (supplyLevel < lowBattThreshold);
  // only host-mode pulses count toward the tail
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      tailCnt <= 9'h000;
    else if (oscEnable)
      tailCnt <= 9'h000;
    else if ($rose(hostClockOut) && hostClockEn && !$past(oscEnable))
      tailCnt <= tailCnt + 9'h001;
  end
  // cycles since the timer was enabled with the oscillator off; stops at 1200
  logic [10:0] calAge;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      calAge <= 11'h000;
    else if ($rose(wutEnable) && !oscEnable)
      calAge <= 11'h001;
    else if (calAge != 11'h000 && calAge != 11'h4B0)
      calAge <= calAge + 11'h001;
  end
  sequence calWin;
    oscRun [*8];
  endsequence
  sequence quietLink;
    serial_select_n [*5];
  endsequence
  // ----
  // checks
  // ----
  chk_tail_limit: assert property (!oscEnable |-> tailCnt <= 9'h080)
    else $error("host clock ran past its tail");
  chk_cal_window: assert property ($rose(wutEnable) && !oscEnable |-> ##[0:4] calWin)
    else $error("calibration oscillator hold wrong");
  chk_cal_hold: assert property
    (!oscEnable && calAge >= 11'h008 && calAge <= 11'h384 |-> oscRun)
    else $error("oscillator dropped during calibration");
  chk_cal_release: assert property (!oscEnable && calAge == 11'h44C |-> !oscRun)
    else $error("oscillator not released after calibration");
  chk_lowbatt_irq: assert property ($rose(lbLow) ##1 quietLink |-> !event_request_n)
    else $error("low supply raised no request");
  chk_irq_hold: assert property (quietLink ##0 !event_request_n |=> !event_request_n)
    else $error("request dropped without status read");
  chk_out_tristate: assert property (serial_select_n [*3] |-> !serialOutEn)
    else $error("serial output driven while deselected");
  chk_out_drive: assert property (!serial_select_n [*4] |-> serialOutEn)
    else $error("serial output not driven while selected");
  chk_out_keep: assert property (serial_select_n [*4] |-> $stable(fifo_irq_or_serial_out))
    else $error("kept serial level changed");
  chk_strap_fixed: assert property (standalone |-> !hostClockEn)
    else $error("host clock enabled in standalone mode");
  chk_mode_stable: assert property ($past(rstn, 2) |-> $stable(standalone))
    else $error("mode changed after power-on");
endmodule
bind weh_control weh_control_assertions chk (.core_clk(core_clk), .rstn(rstn),
  .serial_select_n(serial_select_n), .fifo_irq_or_serial_out(fifo_irq_or_serial_out),
  .serialOutEn(serialOutEn), .event_request_n(event_request_n), .oscEnable(oscEnable),
  .wutEnable(wutEnable), .lowBattEnable(lowBattEnable), .lowBattThreshold(lowBattThreshold),
  .supplyLevel(supplyLevel), .hostClockOut(hostClockOut), .hostClockEn(hostClockEn),
  .standalone(standalone), .oscRun(oscRun));

// File: verif/weh_host_model.sv
module weh_host_model (
  // clock
  input wire logic core_clk,
  // serial pins
  input wire logic fifo_irq_or_serial_out,
  output logic serialClk,
  output logic serial_select_n,
  output logic serial_write_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    serialClk = 1'b0;
    serial_select_n = 1'b1;
    serial_write_in = 1'b0;
  end
  // ----
  // one frame; the status command adds 15 clocks after the byte and samples 16 read bits from the last command clock on
  // ----
  task automatic xfer(input logic [7:0] cmd, output logic [15:0] rd);
    int n;
    n = (cmd == 8'hFF) ? 23 : 8;
    rd = 16'h0000;
    @(posedge core_clk);
    serial_select_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int k = 0; k < n; k++)
    begin
      serial_write_in <= (k < 8) ? cmd[7 - k] : ~serial_write_in;
      repeat (2) @(posedge core_clk);
      serialClk <= 1'b1;
      repeat (4) @(posedge core_clk);
      if (k >= 7)
        rd[22 - k] = fifo_irq_or_serial_out;
      serialClk <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    serial_select_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// File: verif/weh_control_tb_top.sv
module weh_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic serialClk, serial_select_n, serial_write_in;
  logic oscEnable = 1'b1;
  logic [3:0] clkDivHalf = 4'h1;
  logic clkDivEnable = 1'b1;
  logic wutEnable = 1'b0;
  logic [15:0] wutPeriodMs = 16'h0001;
  logic lowBattEnable = 1'b0;
  logic [8:0] lowBattThreshold = 9'h12C;
  logic [8:0] supplyLevel = 9'h190;
  logic fifo_enable_bit = 1'b0;
  logic [3:0] fifoFillLevel = 4'h1;
  logic digitalFilter = 1'b1;
  logic sleepMode = 1'b0;
  logic rxBit = 1'b0;
  logic rxBitStrobe = 1'b0;
  logic fifo_access_select_n = 1'b1;
  logic dutySelectIn = 1'b0;
  logic dutySelectDriven = 1'b0;
  logic [3:0] channelSelect = 4'h0;
  logic [1:0] bandSelect = 2'h0;
  logic [7:0] ownAddress = 8'hA5;
  logic fifo_irq_or_serial_out, serialOutEn, event_request_n, rxDataOut, rxClkOut;
  logic fifo_threshold_flag, hostClockOut, hostClockEn, standalone, dutyCycled;
  logic oscRun, host_reset_n;
  logic [3:0] controlOutputs;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic fq[$];
  always #2.5 core_clk = ~core_clk;
  weh_control uut (.core_clk, .rstn, .serialClk, .serial_select_n, .serial_write_in,
    .fifo_irq_or_serial_out, .serialOutEn, .event_request_n, .oscEnable, .clkDivHalf,
    .clkDivEnable, .wutEnable, .wutPeriodMs, .lowBattEnable, .lowBattThreshold, .supplyLevel,
    .fifo_enable_bit, .fifoFillLevel, .digitalFilter, .sleepMode, .rxBit, .rxBitStrobe,
    .fifo_access_select_n, .rxDataOut, .rxClkOut, .fifo_threshold_flag, .dutySelectIn,
    .dutySelectDriven, .hostClockOut, .hostClockEn, .standalone, .dutyCycled, .oscRun,
    .host_reset_n, .channelSelect, .bandSelect, .ownAddress, .controlOutputs);
  weh_host_model host (.core_clk, .fifo_irq_or_serial_out, .serialClk, .serial_select_n,
    .serial_write_in);
  // ----
  // helpers
  // ----
  task automatic end_of_test();
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic do_reset(input logic strap);
    rstn <= 1'b0;
    dutySelectDriven <= strap;
    cyc(8);
    rstn <= 1'b1;
    cyc(4);
  endtask
  // the read reports the causes latched before its own clear
  task automatic status(input logic [3:0] cause, input logic lb, input logic sa);
    logic [15:0] rd;
    host.xfer(8'hFF, rd);
    cmp({5'h00, rd[15:5]}, {5'h00, cause, 5'(fq.size()), lb, sa});
  endtask
  task automatic push(input logic v);
    rxBit <= v;
    rxBitStrobe <= 1'b1;
    cyc(1);
    rxBitStrobe <= 1'b0;
    cyc(1);
    if (fifo_enable_bit)
      fq.push_back(v);
    else
      cmp({14'h0000, rxClkOut, rxDataOut}, {14'h0000, digitalFilter, v});
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    int cnt;
    logic [15:0] rd;
    logic [7:0] b;
    logic [3:0] nib;
    logic prv;
    void'($urandom(32'hB3CA14EB));
    do_reset(1'b0);
    cmp({13'h0000, standalone, hostClockEn, host_reset_n}, 16'h0003);
    clkDivHalf <= 4'($urandom_range(3, 0));
    cyc(20);
    oscEnable <= 1'b0;
    // a rise launched on the clearing edge itself is not part of the tail
    cyc(1);
    prv = hostClockOut;
    cnt = 0;
    for (int i = 0; i < 2000; i++)
    begin
      cyc(1);
      cnt += (hostClockOut === 1'b1 && prv === 1'b0) ? 1 : 0;
      prv = hostClockOut;
    end
    cmp(16'(cnt), 16'h0080);
    cmp({15'h0000, hostClockOut}, 16'h0000);
    wutEnable <= 1'b1;
    cyc(20);
    cmp({15'h0000, oscRun}, 16'h0001);
    cyc(1200);
    cmp({15'h0000, oscRun}, 16'h0000);
    b = 8'($urandom_range(254, 0));
    host.xfer(b, rd);
    cyc(4);
    cmp({15'h0000, event_request_n}, 16'h0000);
    status(4'h8, 1'b0, 1'b0);
    cmp({15'h0000, event_request_n}, 16'h0001);
    push(1'b1);
    cmp({15'h0000, fifo_threshold_flag}, 16'h0000);
    fifo_enable_bit <= 1'b1;
    cyc(2);
    for (int i = 0; i < 16; i++)
    begin
      push(1'($urandom));
      cyc(2);
      if (i == 0)
        cmp({15'h0000, fifo_threshold_flag}, 16'h0001);
    end
    cmp({15'h0000, event_request_n}, 16'h0000);
    status(4'h4, 1'b0, 1'b0);
    while (fq.size() > 0)
    begin
      fifo_access_select_n <= 1'b0;
      cyc(2);
      cmp({15'h0000, rxDataOut}, {15'h0000, fq.pop_front()});
      fifo_access_select_n <= 1'b1;
      cyc(2);
    end
    cyc(2);
    cmp({15'h0000, fifo_threshold_flag}, 16'h0000);
    lowBattEnable <= 1'b1;
    sleepMode <= 1'b1;
    cyc(4);
    supplyLevel <= 9'h12B;
    cyc(10);
    cmp({15'h0000, event_request_n}, 16'h0000);
    status(4'h2, 1'b1, 1'b0);
    supplyLevel <= 9'h12E;
    cyc(5);
    status(4'h0, 1'b1, 1'b0);
    supplyLevel <= 9'h131;
    cyc(5);
    status(4'h0, 1'b0, 1'b0);
    do_reset(1'b1);
    cmp({14'h0000, standalone, hostClockEn}, 16'h0002);
    dutySelectIn <= 1'b1;
    sleepMode <= 1'b0;
    channelSelect <= 4'($urandom);
    bandSelect <= 2'($urandom);
    nib = 4'($urandom);
    cyc(4);
    cmp({15'h0000, dutyCycled}, 16'h0001);
    host.xfer({ownAddress[7:4], nib}, rd);
    cyc(4);
    cmp({12'h000, controlOutputs}, {12'h000, nib ^ {channelSelect[1:0], bandSelect}});
    host.xfer({~ownAddress[7:4], ~nib}, rd);
    cyc(4);
    cmp({12'h000, controlOutputs}, {12'h000, nib ^ {channelSelect[1:0], bandSelect}});
    end_of_test();
  end
endmodule
